/* include/pb_seq_defines.vh */
// timing counts and event bit positions for the power sequencer
`ifndef PB_SEQ_DEFINES_VH
`define PB_SEQ_DEFINES_VH
`define CLK_HZ            25000000
`define DEBOUNCE_MS       24
`define DEBOUNCE_CYCLES   ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define RESET_DUR_CYCLES  250000
`define ADDR_STATUS       8'h00
`define ADDR_CLEAR        8'h04
`define ADDR_ENABLE       8'h08
`define ADDR_STATE        8'h0c
`define ADDR_MODE         8'h10
`define EV_KEY_PRESS      0
`define EV_KEY_RELEASE    1
`define EV_POWER_UP_DONE  2
`define EV_POWER_DOWN     3
`define EV_FAULT          4
`define EV_WIDTH          5
`define ENABLE_RESET      5'h00
`define MODE_RESET        1'b0
`endif

/* core/key_debounce.v */
// three-stage pin synchroniser and debounce counter
`timescale 1ns/10ps
`default_nettype none
module key_debounce #(
   parameter CNT_W  = 20,
   parameter LENGTH = 600000
) (
   input  wire clk_in,
   input  wire resetn_in,
   input  wire pin_in,
   output reg  level_out
);
   reg             s1_r;
   reg             s2_r;
   reg             s3_r;
   reg [CNT_W-1:0] cnt_r;

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_r      <= 1'b1;
         s2_r      <= 1'b1;
         s3_r      <= 1'b1;
         cnt_r     <= {CNT_W{1'b0}};
         level_out <= 1'b1;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // a change only counts once stages two and three agree
         if (s2_r != s3_r || s3_r == level_out) begin
            cnt_r <= {CNT_W{1'b0}};
         end else if (cnt_r == LENGTH[CNT_W-1:0] - 1'b1) begin
            cnt_r     <= {CNT_W{1'b0}};
            level_out <= s3_r;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule // key_debounce
`default_nettype wire

/* core/pin_sync.v */
// three-stage synchroniser for level inputs from outside the clock
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         resetn_in,
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1_r  <= {W{1'b0}};
         s2_r  <= {W{1'b0}};
         s3_r  <= {W{1'b0}};
         q_out <= {W{1'b0}};
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // only agreeing samples update the output
         if (s2_r == s3_r) begin
            q_out <= s3_r;
         end
      end
   end
endmodule // pin_sync
`default_nettype wire

/* core/pushbutton_power_sequencer.v */
// pushbutton power sequencer with axi4-lite status and interrupt
//
// Overview of operation
// - mode input high puts all converters in fixed-frequency pwm.
// - mode input low allows pulse skipping, buck-boost skipping only.
// - power hold high enables the device regardless of the key.
// - key low starts the ordered power-up and a processor reset cycle.
// - open-drain key status output shows the debounced key level.
// - reset stays low until all enabled rails are good plus the duration.
// - reset is held low on fault and while the device is disabled.
// - switched output closes only after the buck-boost is in regulation.
// - buck-boost runs only with its enable high and the device enabled.
// - each step-down runs only with its enable high and device enabled.
// - order is step-down one, step-down two, buck-boost, each after good.
// - key must stay low past the debounce interval before acting.
// - a stage whose enable is low is skipped in the order.
// - key release without power hold disables and discharges outputs.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pb_seq_defines.vh"
module pushbutton_power_sequencer #(
   parameter DEBOUNCE_CYCLES  = `DEBOUNCE_CYCLES,
   parameter RESET_DUR_CYCLES = `RESET_DUR_CYCLES
) (
   input  wire        REF_CLK_IN,
   input  wire        RESETN_IN,
   input  wire        PUSHBUTTON_KEY_N_IN,
   input  wire        POWER_HOLD_IN,
   input  wire        MODE_PWM_IN,
   input  wire        STEP_DOWN_ONE_ENABLE_IN,
   input  wire        STEP_DOWN_TWO_ENABLE_IN,
   input  wire        BUCK_BOOST_ENABLE_IN,
   input  wire        STEP_DOWN_ONE_GOOD_IN,
   input  wire        STEP_DOWN_TWO_GOOD_IN,
   input  wire        BUCK_BOOST_GOOD_IN,
   input  wire        FAULT_IN,
   output reg         KEY_STATUS_N_OUT,
   output reg         KEY_STATUS_N_OE_OUT,
   output reg         CPU_RESET_N_OUT,
   output reg         STEP_DOWN_ONE_RUN_OUT,
   output reg         STEP_DOWN_TWO_RUN_OUT,
   output reg         BUCK_BOOST_RUN_OUT,
   output reg         PROTECTED_SWITCHED_OUTPUT_OUT,
   output reg         DISCHARGE_OUT,
   output reg         FORCE_PWM_OUT,
   output reg         BUCK_BOOST_SKIP_ONLY_OUT,
   output reg         IRQ_OUT,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY
);
   localparam ST_OFF   = 3'd0;
   localparam ST_SD1   = 3'd1;
   localparam ST_SD2   = 3'd2;
   localparam ST_BB    = 3'd3;
   localparam ST_RESET = 3'd4;
   localparam ST_ON    = 3'd5;
   localparam RW       = 20;

   wire                 key_n;
   wire [5:0]           sync_q;
   wire                 hold;
   wire                 pwm;
   wire                 en1;
   wire                 en2;
   wire                 en3;
   wire                 pg1;
   wire                 pg2;
   wire                 pg3;
   wire                 fault;
   reg  [2:0]           state_r;
   reg  [2:0]           state_nxt;
   reg  [RW-1:0]        rst_cnt_r;
   reg                  key_d_r;
   reg  [`EV_WIDTH-1:0] status_r;
   reg  [`EV_WIDTH-1:0] enable_r;
   reg  [`EV_WIDTH-1:0] events;
   reg                  aw_got_r;
   reg                  w_got_r;
   reg  [7:0]           aw_addr_r;
   reg  [31:0]          w_data_r;
   reg                  w_strb0_r;
   reg                  sw_pwm_r;
   reg  [`EV_WIDTH-1:0] clr_now;
   wire                 do_write;
   wire                 enabled;

   key_debounce #(
      .CNT_W     (RW),
      .LENGTH    (DEBOUNCE_CYCLES)
   ) u_key (
      .clk_in    (REF_CLK_IN),
      .resetn_in (RESETN_IN),
      .pin_in    (PUSHBUTTON_KEY_N_IN),
      .level_out (key_n)
   );

   pin_sync #(
      .W         (6)
   ) u_sync (
      .clk_in    (REF_CLK_IN),
      .resetn_in (RESETN_IN),
      .d_in      ({POWER_HOLD_IN, MODE_PWM_IN, STEP_DOWN_ONE_ENABLE_IN,
                   STEP_DOWN_TWO_ENABLE_IN, BUCK_BOOST_ENABLE_IN,
                   FAULT_IN}),
      .q_out     (sync_q)
   );
   assign hold  = sync_q[5];
   assign pwm   = sync_q[4];
   assign en1   = sync_q[3];
   assign en2   = sync_q[2];
   assign en3   = sync_q[1];
   assign fault = sync_q[0];

   pin_sync #(
      .W         (3)
   ) u_good (
      .clk_in    (REF_CLK_IN),
      .resetn_in (RESETN_IN),
      .d_in      ({STEP_DOWN_ONE_GOOD_IN, STEP_DOWN_TWO_GOOD_IN,
                   BUCK_BOOST_GOOD_IN}),
      .q_out     ({pg1, pg2, pg3})
   );

   // device stays on while key held or hold high
   assign enabled   = hold | ~key_n;

   // power-up order with skipping of disabled stages
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (enabled) begin
               state_nxt = ST_SD1;
            end
         end
         ST_SD1: begin
            if (!en1 || pg1) begin
               state_nxt = ST_SD2;
            end
         end
         ST_SD2: begin
            if (!en2 || pg2) begin
               state_nxt = ST_BB;
            end
         end
         ST_BB: begin
            if (!en3 || pg3) begin
               state_nxt = ST_RESET;
            end
         end
         ST_RESET: begin
            if (rst_cnt_r == RESET_DUR_CYCLES[RW-1:0] - 1'b1) begin
               state_nxt = ST_ON;
            end
         end
         ST_ON: begin
            state_nxt = ST_ON;
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
      // release without hold shuts everything down
      if (state_r != ST_OFF && !enabled) begin
         state_nxt = ST_OFF;
      end
   end

   always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_r   <= ST_OFF;
         rst_cnt_r <= {RW{1'b0}};
         key_d_r   <= 1'b1;
      end else begin
         state_r <= state_nxt;
         key_d_r <= key_n;
         if (state_r == ST_RESET && state_nxt == ST_RESET) begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
         end else begin
            rst_cnt_r <= {RW{1'b0}};
         end
      end
   end

   // pin-facing outputs, all registered
   always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         KEY_STATUS_N_OUT              <= 1'b0;
         KEY_STATUS_N_OE_OUT           <= 1'b0;
         CPU_RESET_N_OUT               <= 1'b0;
         STEP_DOWN_ONE_RUN_OUT         <= 1'b0;
         STEP_DOWN_TWO_RUN_OUT         <= 1'b0;
         BUCK_BOOST_RUN_OUT            <= 1'b0;
         PROTECTED_SWITCHED_OUTPUT_OUT <= 1'b0;
         DISCHARGE_OUT                 <= 1'b1;
         FORCE_PWM_OUT                 <= 1'b0;
         BUCK_BOOST_SKIP_ONLY_OUT      <= 1'b1;
      end else begin
         // open drain: drive low only while key is down
         KEY_STATUS_N_OUT    <= 1'b0;
         KEY_STATUS_N_OE_OUT <= ~key_n;
         // rails stay on once reached, gated by own enable
         STEP_DOWN_ONE_RUN_OUT <= en1 && state_nxt != ST_OFF;
         STEP_DOWN_TWO_RUN_OUT <= en2 && state_nxt != ST_OFF
                                  && state_nxt != ST_SD1;
         BUCK_BOOST_RUN_OUT    <= en3 && (state_nxt == ST_BB
                                  || state_nxt == ST_RESET
                                  || state_nxt == ST_ON);
         PROTECTED_SWITCHED_OUTPUT_OUT <= en3 && pg3
            && (state_nxt == ST_RESET || state_nxt == ST_ON);
         DISCHARGE_OUT   <= (state_nxt == ST_OFF);
         CPU_RESET_N_OUT <= (state_nxt == ST_ON) && !fault;
         // software may also force pwm
         FORCE_PWM_OUT            <= pwm | sw_pwm_r;
         BUCK_BOOST_SKIP_ONLY_OUT <= ~(pwm | sw_pwm_r);
      end
   end

   always @* begin
      events = {`EV_WIDTH{1'b0}};
      events[`EV_KEY_PRESS]     = key_d_r & ~key_n;
      events[`EV_KEY_RELEASE]   = ~key_d_r & key_n;
      events[`EV_POWER_UP_DONE] = (state_r == ST_RESET)
                                  && (state_nxt == ST_ON);
      events[`EV_POWER_DOWN]    = (state_r != ST_OFF)
                                  && (state_nxt == ST_OFF);
      events[`EV_FAULT]         = fault && (state_r == ST_ON);
   end

   // axi4-lite write: address and data taken in either order
   assign do_write = aw_got_r && w_got_r && !S_AXI_BVALID;

   always @* begin
      clr_now = {`EV_WIDTH{1'b0}};
      if (do_write && aw_addr_r == `ADDR_CLEAR && w_strb0_r) begin
         clr_now = w_data_r[`EV_WIDTH-1:0];
      end
   end

   always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= 2'b00;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h00000000;
         w_strb0_r     <= 1'b0;
         status_r      <= {`EV_WIDTH{1'b0}};
         enable_r      <= `ENABLE_RESET;
         sw_pwm_r      <= `MODE_RESET;
         IRQ_OUT       <= 1'b0;
      end else begin
         S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY  <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_r  <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            // strobe is only valid with wvalid, so keep it with the data
            w_strb0_r <= S_AXI_WSTRB[0];
         end
         if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            S_AXI_BRESP  <= 2'b00;
            if (aw_addr_r == `ADDR_ENABLE && w_strb0_r) begin
               enable_r <= w_data_r[`EV_WIDTH-1:0];
            end else if (aw_addr_r == `ADDR_MODE && w_strb0_r) begin
               sw_pwm_r <= w_data_r[0];
            end else if (aw_addr_r != `ADDR_CLEAR) begin
               S_AXI_BRESP <= 2'b10;
            end
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         // set wins over clear in the same cycle
         status_r <= (status_r & ~clr_now) | events;
         IRQ_OUT  <= |(((status_r & ~clr_now) | events) & enable_r);
      end
   end

   // axi4-lite read
   always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= 2'b00;
      end else begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= 2'b00;
            case (S_AXI_ARADDR)
               `ADDR_STATUS: S_AXI_RDATA <= {27'h0000000, status_r};
               `ADDR_CLEAR:  S_AXI_RDATA <= 32'h00000000;
               `ADDR_ENABLE: S_AXI_RDATA <= {27'h0000000, enable_r};
               `ADDR_STATE:  S_AXI_RDATA <= {26'h0000000, CPU_RESET_N_OUT,
                                             ~key_n, hold, state_r};
               `ADDR_MODE:   S_AXI_RDATA <= {31'h00000000, sw_pwm_r};
               default: begin
                  S_AXI_RDATA <= 32'h00000000;
                  S_AXI_RRESP <= 2'b10;
               end
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end
endmodule // pushbutton_power_sequencer
`default_nettype wire

/* verification/pb_seq_asserts.sv */
// pin-level checks bound into the power sequencer
`timescale 1ns/10ps
`default_nettype none
module pb_seq_checker #(
   parameter DEBOUNCE_CYCLES  = 8,
   parameter RESET_DUR_CYCLES = 8
) (
   input wire logic REF_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic PUSHBUTTON_KEY_N_IN,
   input wire logic MODE_PWM_IN,
   input wire logic STEP_DOWN_ONE_ENABLE_IN,
   input wire logic BUCK_BOOST_ENABLE_IN,
   input wire logic STEP_DOWN_ONE_GOOD_IN,
   input wire logic BUCK_BOOST_GOOD_IN,
   input wire logic FAULT_IN,
   input wire logic KEY_STATUS_N_OE_OUT,
   input wire logic CPU_RESET_N_OUT,
   input wire logic STEP_DOWN_TWO_RUN_OUT,
   input wire logic BUCK_BOOST_RUN_OUT,
   input wire logic PROTECTED_SWITCHED_OUTPUT_OUT,
   input wire logic DISCHARGE_OUT,
   input wire logic FORCE_PWM_OUT,
   input wire logic BUCK_BOOST_SKIP_ONLY_OUT
);
   // saturating run lengths of key low and of device on
   logic [19:0] low_cnt_r;
   logic [19:0] on_cnt_r;
   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         low_cnt_r <= 20'h0;
         on_cnt_r  <= 20'h0;
      end else begin
         if (PUSHBUTTON_KEY_N_IN) low_cnt_r <= 20'h0;
         else low_cnt_r <= low_cnt_r + 20'(~&low_cnt_r);
         if (DISCHARGE_OUT) on_cnt_r <= 20'h0;
         else on_cnt_r <= on_cnt_r + 20'(~&on_cnt_r);
      end
   end
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   a_pwm_from_pin: assert property (
      MODE_PWM_IN [*6] |-> FORCE_PWM_OUT) else $error("pwm not forced");
   a_skip_is_inverse: assert property (
      BUCK_BOOST_SKIP_ONLY_OUT != FORCE_PWM_OUT) else $error("skip mode bad");
   a_reset_while_off: assert property (
      DISCHARGE_OUT && $past(DISCHARGE_OUT) |-> !CPU_RESET_N_OUT)
      else $error("reset released while off");
   a_fault_holds_reset: assert property (
      FAULT_IN [*6] |-> !CPU_RESET_N_OUT) else $error("reset high in fault");
   a_switch_after_good: assert property (
      $rose(PROTECTED_SWITCHED_OUTPUT_OUT) |-> $past(BUCK_BOOST_GOOD_IN, 3))
      else $error("switch closed early");
   a_bb_needs_enable: assert property (
      !BUCK_BOOST_ENABLE_IN [*6] |-> !BUCK_BOOST_RUN_OUT)
      else $error("buck-boost runs while disabled");
   a_stage_order: assert property (
      $rose(STEP_DOWN_TWO_RUN_OUT) |->
         !STEP_DOWN_ONE_ENABLE_IN || $past(STEP_DOWN_ONE_GOOD_IN, 3))
      else $error("second stage out of order");
   a_reset_duration: assert property (
      $rose(CPU_RESET_N_OUT) |-> on_cnt_r > RESET_DUR_CYCLES)
      else $error("reset released too soon");
   a_key_debounced: assert property (
      $rose(KEY_STATUS_N_OE_OUT) |-> low_cnt_r > DEBOUNCE_CYCLES)
      else $error("key status before debounce");
endmodule // pb_seq_checker
bind pushbutton_power_sequencer pb_seq_checker #(
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RESET_DUR_CYCLES(RESET_DUR_CYCLES)
) chk_i (
   .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN),
   .PUSHBUTTON_KEY_N_IN(PUSHBUTTON_KEY_N_IN), .MODE_PWM_IN(MODE_PWM_IN),
   .STEP_DOWN_ONE_ENABLE_IN(STEP_DOWN_ONE_ENABLE_IN),
   .BUCK_BOOST_ENABLE_IN(BUCK_BOOST_ENABLE_IN),
   .STEP_DOWN_ONE_GOOD_IN(STEP_DOWN_ONE_GOOD_IN),
   .BUCK_BOOST_GOOD_IN(BUCK_BOOST_GOOD_IN), .FAULT_IN(FAULT_IN),
   .KEY_STATUS_N_OE_OUT(KEY_STATUS_N_OE_OUT),
   .CPU_RESET_N_OUT(CPU_RESET_N_OUT),
   .STEP_DOWN_TWO_RUN_OUT(STEP_DOWN_TWO_RUN_OUT),
   .BUCK_BOOST_RUN_OUT(BUCK_BOOST_RUN_OUT),
   .PROTECTED_SWITCHED_OUTPUT_OUT(PROTECTED_SWITCHED_OUTPUT_OUT),
   .DISCHARGE_OUT(DISCHARGE_OUT), .FORCE_PWM_OUT(FORCE_PWM_OUT),
   .BUCK_BOOST_SKIP_ONLY_OUT(BUCK_BOOST_SKIP_ONLY_OUT));
`default_nettype wire

/* verification/rail_host_model.sv */
// far side: rails reporting good, and a host that holds power
`timescale 1ns/10ps
`default_nettype none
module rail_host_model (
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic [2:0] run_in,
   input  wire logic       cpu_reset_n_in,
   input  wire logic       host_en_in,
   output logic      [2:0] good_out,
   output logic            hold_out
);
   logic [2:0] d1_r;
   logic [2:0] d2_r;
   logic [2:0] d3_r;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         d1_r     <= 3'h0;
         d2_r     <= 3'h0;
         d3_r     <= 3'h0;
         hold_out <= 1'b0;
      end else begin
         d1_r     <= run_in;
         d2_r     <= d1_r & run_in;
         d3_r     <= d2_r & run_in;
         // raise hold once out of reset, drop it to power down
         hold_out <= host_en_in & (hold_out | cpu_reset_n_in);
      end
   end
   // a rail that stops collapses at once, so good never lingers
   assign good_out = d3_r & run_in;
endmodule // rail_host_model
`default_nettype wire

/* verification/pushbutton_power_sequencer_tb.sv */
// self-checking bench for the pushbutton power sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pb_seq_defines.vh"
module pushbutton_power_sequencer_tb;
   logic        clk = 1'b0, rstn = 1'b0, key_n = 1'b1, hold = 1'b0;
   logic        host_en = 1'b0, mode = 1'b0, fault = 1'b0;
   logic [2:0]  en = 3'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd_v;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [1:0]  resp;
   wire  [2:0]  g, r;
   wire         m_hold, ks, oe, cpu, pso, dis, pwm, skip, irq;
   wire         awrdy, wrdy, bvalid, arrdy, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         ks_pin = oe ? ks : 1'b1;
   integer      err_total = 0, checked = 0, cyc = 0, i;
   // {mode, en1, en2, en3} -> {pwm, run1, run2, run3, switch}
   logic [8:0]  rows [6] = '{9'h1ff, 9'h0ef, 9'h1bb, 9'h1dc, 9'h067, 9'h110};
   pushbutton_power_sequencer #(.DEBOUNCE_CYCLES(8), .RESET_DUR_CYCLES(8)) uut (
      .REF_CLK_IN(clk), .RESETN_IN(rstn), .PUSHBUTTON_KEY_N_IN(key_n),
      .POWER_HOLD_IN(hold | m_hold), .MODE_PWM_IN(mode), .FAULT_IN(fault),
      .STEP_DOWN_ONE_ENABLE_IN(en[2]), .STEP_DOWN_TWO_ENABLE_IN(en[1]),
      .BUCK_BOOST_ENABLE_IN(en[0]), .STEP_DOWN_ONE_GOOD_IN(g[2]),
      .STEP_DOWN_TWO_GOOD_IN(g[1]), .BUCK_BOOST_GOOD_IN(g[0]),
      .KEY_STATUS_N_OUT(ks), .KEY_STATUS_N_OE_OUT(oe), .CPU_RESET_N_OUT(cpu),
      .STEP_DOWN_ONE_RUN_OUT(r[2]), .STEP_DOWN_TWO_RUN_OUT(r[1]),
      .BUCK_BOOST_RUN_OUT(r[0]), .PROTECTED_SWITCHED_OUTPUT_OUT(pso),
      .DISCHARGE_OUT(dis), .FORCE_PWM_OUT(pwm),
      .BUCK_BOOST_SKIP_ONLY_OUT(skip), .IRQ_OUT(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awrdy),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   rail_host_model far (.clk_in(clk), .resetn_in(rstn), .run_in(r),
      .cpu_reset_n_in(cpu), .host_en_in(host_en), .good_out(g),
      .hold_out(m_hold));
   always #20 clk = ~clk;
   task summarize;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // timeout: the whole sequence needs well under 3000 cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         summarize;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge clk);
   endtask
   task wait_up;
      integer n;
      for (n = 0; cpu !== 1'b1 && n < 300; n = n + 1) @(posedge clk);
   endtask
   // an edge first, so back-to-back calls never re-drive a ready in one step
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awrdy === 1'b1) awvalid <= 1'b0;
         if (wrdy === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task rd(input [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arrdy === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   initial begin
      tick(15);
      chk({cpu, dis, r, pso, ks_pin, irq, skip}, 9'h085);
      tick(1);
      rstn <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         {mode, en} <= rows[i][8:5];
         tick(8);
         hold <= 1'b1;
         wait_up;
         chk({pwm, skip}, {rows[i][4], ~rows[i][4]});
         chk({r, pso}, rows[i][3:0]);
         chk(cpu, 1'b1);
         hold <= 1'b0;
         tick(10);
         chk({dis, cpu, r}, 5'h10);
      end
      $display("rail table done");
      key_n <= 1'b0;
      tick(5);
      key_n <= 1'b1;
      tick(12);
      chk({ks_pin, dis}, 2'b11);
      // all rails back on so the key power-up really sequences
      en <= 3'h7;
      rd(`ADDR_ENABLE);
      chk(rd_v, 32'h0);
      wr(`ADDR_ENABLE, 32'h2);
      wr(`ADDR_CLEAR, 32'h1f);
      key_n <= 1'b0;
      wait_up;
      chk({ks_pin, r[2], cpu, irq}, 4'b0110);
      rd(`ADDR_STATUS);
      chk(rd_v, 32'h5);
      key_n <= 1'b1;
      tick(16);
      chk({ks_pin, dis, cpu, irq}, 4'b1101);
      rd(`ADDR_STATUS);
      chk(rd_v, 32'hf);
      wr(`ADDR_CLEAR, 32'h1f);
      tick(2);
      chk(irq, 1'b0);
      $display("key and interrupt done");
      host_en <= 1'b1;
      key_n <= 1'b0;
      wait_up;
      tick(8);
      key_n <= 1'b1;
      tick(16);
      chk({dis, cpu, ks_pin}, 3'b011);
      fault <= 1'b1;
      tick(8);
      chk(cpu, 1'b0);
      rd(`ADDR_STATUS);
      chk(rd_v[4], 1'b1);
      fault <= 1'b0;
      wait_up;
      chk({dis, cpu}, 2'b01);
      rstn <= 1'b0;
      tick(2);
      chk({cpu, dis, r}, 5'h08);
      rstn <= 1'b1;
      tick(20);
      chk({cpu, dis}, 2'b01);
      host_en <= 1'b0;
      $display("hold, fault and reset done");
      rd(8'h20);
      chk({resp, rd_v[29:0]}, 32'h80000000);
      wr(8'h24, 32'h1);
      chk(resp, 2'b10);
      $display("unmapped access done");
      mode <= 1'b0;
      wr(`ADDR_MODE, 32'h1);
      rd(`ADDR_MODE);
      chk(rd_v, 32'h1);
      chk({pwm, skip}, 2'b10);
      wr(`ADDR_MODE, 32'h0);
      tick(2);
      chk({pwm, skip}, 2'b01);
      $display("software mode done");
      summarize;
   end
endmodule // pushbutton_power_sequencer_tb
`default_nettype wire
